// >>> fwp_pkg.sv
// Purpose: shared constants and types for the flash write-protect and status block
// Assumes: 2-Mbit array, 18-bit byte address, SPI modes 0 and 3
// Notes: opcodes are the serial command bytes the block decodes
package fwp_pkg;

  localparam int ADDR_W = 18;

  // command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_ENABLE_STATUS_WRITE = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_READ_SECTOR_LOCK = 8'h35;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_BYTE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_AAI_PROGRAM = 8'hAD;

  // frame lengths in bytes, opcode included
  localparam logic [2:0] LEN_OPCODE_ONLY = 3'h1;
  localparam logic [2:0] LEN_ERASE = 3'h4;
  localparam logic [2:0] LEN_BYTE_PROGRAM = 3'h5;
  localparam logic [2:0] LEN_AAI_FIRST = 3'h6;
  localparam logic [2:0] LEN_AAI_NEXT = 3'h3;
  localparam logic [2:0] LEN_STATUS_ONE = 3'h2;
  localparam logic [2:0] LEN_STATUS_TWO = 3'h3;

  // primary status bit positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LO_BIT = 2;
  localparam int ST_BP_HI_BIT = 3;
  localparam int ST_AAI_BIT = 6;
  localparam int ST_LOCK_BIT = 7;
  // sector lock status bit positions
  localparam int SL_TOP_BIT = 2;
  localparam int SL_BOTTOM_BIT = 3;

  // reset values
  localparam logic RST_BUSY = 1'b0;
  localparam logic RST_WEL = 1'b0;
  localparam logic RST_AAI = 1'b0;
  localparam logic [1:0] RST_BLOCK_PROTECT = 2'h3;
  localparam logic RST_LOCKDOWN = 1'b0;
  localparam logic RST_SECTOR_LOCK = 1'b0;

  // protected regions
  localparam logic [ADDR_W-1:0] ARRAY_BASE = 18'h00000;
  localparam logic [ADDR_W-1:0] ARRAY_TOP = 18'h3FFFF;
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 18'h30000;
  localparam logic [ADDR_W-1:0] HALF_BASE = 18'h20000;
  localparam logic [ADDR_W-1:0] FULL_BASE = 18'h00000;
  localparam logic [ADDR_W-1:0] TOP_SECTOR_BASE = 18'h3F000;
  localparam logic [ADDR_W-1:0] BOTTOM_SECTOR_END = 18'h00FFF;

  typedef enum logic [2:0] {
    FWP_OP_BYTE_PROGRAM,
    FWP_OP_AAI_WORD,
    FWP_OP_SECTOR_ERASE,
    FWP_OP_BLOCK32_ERASE,
    FWP_OP_BLOCK64_ERASE,
    FWP_OP_CHIP_ERASE
  } fwp_op_t;

  typedef struct packed {
    logic valid;
    fwp_op_t op;
    logic [ADDR_W-1:0] start_addr;
    logic [ADDR_W-1:0] end_addr;
    logic [15:0] data;
  } fwp_array_req_t;

  typedef struct packed {
    logic frame_start;
    logic frame_end;
    logic cs_active;
    logic byte_stb;
    logic [7:0] rx_byte;
    logic sck_fall;
    logic wp_n;
  } fwp_spi_evt_t;

endpackage : fwp_pkg

// >>> fwp_spi_rx.sv
// Purpose: pin synchroniser and serial byte assembler for the command port
// Assumes: sck is sampled by clk_sys, at least four clk_sys periods per half sck
// Notes: frame, byte and sck edge event outputs are registered one-cycle pulses; cs_active and wp_n are registered levels
`timescale 1ns/1ps
module fwp_spi_rx (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic wp_n,
  output fwp_pkg::fwp_spi_evt_t evt
);
  import fwp_pkg::*;

  logic [3:0] meta;
  logic [3:0] sync;
  logic sck_prev;
  logic cs_n_prev;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  // two-flop synchroniser: sck, cs_n, mosi, wp_n
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta <= 4'hB;
      sync <= 4'hB;
    end else begin
      meta <= {wp_n, spi_mosi, spi_cs_n, spi_sck};
      sync <= meta;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sck_prev <= 1'b0;
      cs_n_prev <= 1'b1;
    end else begin
      sck_prev <= sync[0];
      cs_n_prev <= sync[1];
    end
  end

  assign sck_rise = sync[0] && !sck_prev && !sync[1];
  assign sck_fall = !sync[0] && sck_prev && !sync[1];
  assign cs_fall = !sync[1] && cs_n_prev;
  assign cs_rise = sync[1] && !cs_n_prev;

  // msb-first byte assembly on sck rising edges
  always_ff @(posedge clk_sys) begin
    if (srst || cs_fall) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= {shift[5:0], sync[2]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      evt <= '0;
      evt.wp_n <= 1'b1;
    end else begin
      evt.frame_start <= cs_fall;
      evt.frame_end <= cs_rise;
      evt.cs_active <= !sync[1];
      evt.byte_stb <= sck_rise && (bit_cnt == 3'h7);
      if (sck_rise && (bit_cnt == 3'h7)) begin
        evt.rx_byte <= {shift, sync[2]};
      end
      evt.sck_fall <= sck_fall;
      evt.wp_n <= sync[3];
    end
  end

endmodule : fwp_spi_rx

// >>> fwp_top.sv
// Purpose: write-protect, status registers and command gating of a serial flash
// Assumes: array engine on clk_sys executes requests and pulses array_done
// Notes: commands execute at chip-select release; reads repeat the status byte
`timescale 1ns/1ps
module fwp_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic wp_n,
  input wire logic array_done,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  output fwp_pkg::fwp_array_req_t array_req
);
  import fwp_pkg::*;

  fwp_spi_evt_t evt;
  logic busy;
  logic write_enable_latch;
  logic auto_increment_program_flag;
  logic block_protect_lo;
  logic block_protect_hi;
  logic protect_lockdown;
  logic top_sector_lock;
  logic bottom_sector_lock;
  logic aai_last;
  logic [2:0] byte_cnt;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [15:0] data;
  logic [ADDR_W-1:0] aai_addr;
  logic [7:0] tx;
  logic [7:0] primary_status;
  logic [7:0] sector_lock_status;
  logic [ADDR_W-1:0] t_start;
  logic [ADDR_W-1:0] t_end;
  logic [ADDR_W-1:0] next_word;
  logic [ADDR_W-1:0] bp_base;
  logic bp_any;
  logic is_mem_op;
  logic len_ok;
  logic blocked;
  logic next_blocked;
  logic exec_mem;
  logic cmd_ok;
  logic status_write;
  logic status_allowed;
  logic read_active;
  fwp_op_t op_kind;

  fwp_spi_rx u_rx (
    .clk_sys(clk_sys),
    .srst(srst),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .wp_n(wp_n),
    .evt(evt)
  );

  always_comb begin
    primary_status = 8'h00;
    primary_status[ST_BUSY_BIT] = busy;
    primary_status[ST_WEL_BIT] = write_enable_latch;
    primary_status[ST_BP_LO_BIT] = block_protect_lo;
    primary_status[ST_BP_HI_BIT] = block_protect_hi;
    primary_status[ST_AAI_BIT] = auto_increment_program_flag;
    primary_status[ST_LOCK_BIT] = protect_lockdown;
    sector_lock_status = 8'h00;
    sector_lock_status[SL_TOP_BIT] = top_sector_lock;
    sector_lock_status[SL_BOTTOM_BIT] = bottom_sector_lock;
  end

  // frame capture: opcode, three address bytes, last two data bytes
  always_ff @(posedge clk_sys) begin
    if (srst || evt.frame_start) begin
      byte_cnt <= 3'h0;
      addr <= 24'h000000;
      data <= 16'h0000;
      if (srst) begin
        opcode <= 8'h00;
      end
    end else if (evt.byte_stb) begin
      if (byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
      if (byte_cnt == 3'h0) begin
        opcode <= evt.rx_byte;
      end else begin
        data <= {data[7:0], evt.rx_byte};
      end
      if (byte_cnt != 3'h0 && byte_cnt <= 3'h3) begin
        addr <= {addr[15:0], evt.rx_byte};
      end
    end
  end

  // target range of the pending memory command
  always_comb begin
    is_mem_op = 1'b1;
    len_ok = (byte_cnt == LEN_ERASE);
    op_kind = FWP_OP_SECTOR_ERASE;
    t_start = {addr[17:12], 12'h000};
    t_end = {addr[17:12], 12'hFFF};
    case (opcode)
      OP_BYTE_PROGRAM: begin
        op_kind = FWP_OP_BYTE_PROGRAM;
        len_ok = (byte_cnt == LEN_BYTE_PROGRAM);
        t_start = addr[17:0];
        t_end = addr[17:0];
      end
      OP_AAI_PROGRAM: begin
        op_kind = FWP_OP_AAI_WORD;
        len_ok = auto_increment_program_flag ? (byte_cnt == LEN_AAI_NEXT) :
                 (byte_cnt == LEN_AAI_FIRST);
        t_start = auto_increment_program_flag ? aai_addr : {addr[17:1], 1'b0};
        t_end = t_start | 18'h00001;
      end
      OP_SECTOR_ERASE: begin
        op_kind = FWP_OP_SECTOR_ERASE;
      end
      OP_BLOCK32_ERASE: begin
        op_kind = FWP_OP_BLOCK32_ERASE;
        t_start = {addr[17:15], 15'h0000};
        t_end = {addr[17:15], 15'h7FFF};
      end
      OP_BLOCK64_ERASE: begin
        op_kind = FWP_OP_BLOCK64_ERASE;
        t_start = {addr[17:16], 16'h0000};
        t_end = {addr[17:16], 16'hFFFF};
      end
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
        op_kind = FWP_OP_CHIP_ERASE;
        len_ok = (byte_cnt == LEN_OPCODE_ONLY);
        t_start = ARRAY_BASE;
        t_end = ARRAY_TOP;
      end
      default: begin
        is_mem_op = 1'b0;
        len_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    case ({block_protect_hi, block_protect_lo})
      2'b01: bp_base = QUARTER_BASE;
      2'b10: bp_base = HALF_BASE;
      2'b11: bp_base = FULL_BASE;
      default: bp_base = ARRAY_TOP;
    endcase
  end

  assign bp_any = block_protect_hi || block_protect_lo;
  // chip erase ends at the top, so any set protect bit blocks it
  assign blocked = (bp_any && t_end >= bp_base)
                   || (top_sector_lock && t_end >= TOP_SECTOR_BASE)
                   || (bottom_sector_lock && t_start <= BOTTOM_SECTOR_END);
  assign next_word = t_end + 18'h00001;
  assign next_blocked = (t_end == ARRAY_TOP)
                        || (bp_any && next_word >= bp_base)
                        || (top_sector_lock && next_word >= TOP_SECTOR_BASE);

  // while busy only status reads are served
  assign cmd_ok = evt.frame_end && !busy;
  assign exec_mem = cmd_ok && is_mem_op && len_ok && write_enable_latch && !blocked;
  assign status_write = cmd_ok && (opcode == OP_STATUS_WRITE) && write_enable_latch
                        && (byte_cnt == LEN_STATUS_ONE || byte_cnt == LEN_STATUS_TWO);
  assign status_allowed = evt.wp_n || !protect_lockdown;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy <= RST_BUSY;
    end else if (exec_mem) begin
      busy <= 1'b1;
    end else if (array_done) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      write_enable_latch <= RST_WEL;
    end else if (cmd_ok && byte_cnt == LEN_OPCODE_ONLY
                 && (opcode == OP_WRITE_ENABLE || opcode == OP_ENABLE_STATUS_WRITE)) begin
      write_enable_latch <= 1'b1;
    end else if (cmd_ok && byte_cnt == LEN_OPCODE_ONLY && opcode == OP_WRITE_DISABLE) begin
      write_enable_latch <= 1'b0;
    end else if (status_write && status_allowed) begin
      write_enable_latch <= 1'b0;
    end else if (busy && array_done && (!auto_increment_program_flag || aai_last)) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      auto_increment_program_flag <= RST_AAI;
      aai_last <= 1'b0;
      aai_addr <= ARRAY_BASE;
    end else if (exec_mem && op_kind == FWP_OP_AAI_WORD) begin
      auto_increment_program_flag <= 1'b1;
      aai_last <= next_blocked;
      aai_addr <= next_word;
    end else if (cmd_ok && byte_cnt == LEN_OPCODE_ONLY && opcode == OP_WRITE_DISABLE) begin
      auto_increment_program_flag <= 1'b0;
    end else if (busy && array_done && aai_last) begin
      auto_increment_program_flag <= 1'b0;
      aai_last <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      block_protect_lo <= RST_BLOCK_PROTECT[0];
      block_protect_hi <= RST_BLOCK_PROTECT[1];
      protect_lockdown <= RST_LOCKDOWN;
      top_sector_lock <= RST_SECTOR_LOCK;
      bottom_sector_lock <= RST_SECTOR_LOCK;
    end else if (status_write && status_allowed) begin
      if (byte_cnt == LEN_STATUS_ONE) begin
        block_protect_lo <= data[ST_BP_LO_BIT];
        block_protect_hi <= data[ST_BP_HI_BIT];
        protect_lockdown <= data[ST_LOCK_BIT];
      end else begin
        block_protect_lo <= data[8 + ST_BP_LO_BIT];
        block_protect_hi <= data[8 + ST_BP_HI_BIT];
        protect_lockdown <= data[8 + ST_LOCK_BIT];
        top_sector_lock <= data[SL_TOP_BIT];
        bottom_sector_lock <= data[SL_BOTTOM_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      array_req <= '0;
    end else begin
      array_req.valid <= exec_mem;
      if (exec_mem) begin
        array_req.op <= op_kind;
        array_req.start_addr <= t_start;
        array_req.end_addr <= t_end;
        array_req.data <= (op_kind == FWP_OP_BYTE_PROGRAM) ? {8'h00, data[7:0]} : data;
      end
    end
  end

  // status read: reload each byte boundary, shift out on sck falling edges
  assign read_active = evt.cs_active && byte_cnt != 3'h0
                       && (opcode == OP_READ_STATUS || opcode == OP_READ_SECTOR_LOCK);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else if (!evt.cs_active) begin
      spi_miso_oe_n <= 1'b1;
    end else if (evt.byte_stb) begin
      if ((byte_cnt == 3'h0 ? evt.rx_byte : opcode) == OP_READ_SECTOR_LOCK) begin
        tx <= sector_lock_status;
      end else begin
        tx <= primary_status;
      end
    end else if (evt.sck_fall && read_active) begin
      spi_miso <= tx[7];
      spi_miso_oe_n <= 1'b0;
      tx <= {tx[6:0], tx[7]};
    end
  end

endmodule : fwp_top

// >>> fwp_monitor.sv
// Purpose: port-level checks for the write-protect and status block
// Assumes: one clk_sys domain, srst synchronous active high
// Notes: bound to fwp_top below
`timescale 1ns/1ps
module fwp_monitor (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic wp_n,
  input wire logic array_done,
  input wire logic spi_miso,
  input wire logic spi_miso_oe_n,
  input wire fwp_pkg::fwp_array_req_t array_req
);
  import fwp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence cs_idle;
    spi_cs_n [*8];
  endsequence
  sequence req_seen;
    array_req.valid ##1 !array_req.valid;
  endsequence
  a_req_one_pulse: assert property (
    array_req.valid |-> req_seen) else $error("request valid held too long");
  a_req_after_frame: assert property (
    array_req.valid |-> spi_cs_n && $past(spi_cs_n, 2)) else $error("request inside a frame");
  a_oe_idle: assert property (
    cs_idle |-> spi_miso_oe_n) else $error("serial output driven while deselected");
  a_oe_opens_in_frame: assert property (
    $fell(spi_miso_oe_n) |-> !spi_cs_n && !$past(spi_cs_n, 4)) else $error("output opened late");
  a_reset_quiet: assert property (
    $fell(srst) |-> spi_miso_oe_n && array_req == '0) else $error("outputs not at reset level");
  a_chip_range: assert property (
    array_req.valid && array_req.op == FWP_OP_CHIP_ERASE
    |-> array_req.start_addr == ARRAY_BASE && array_req.end_addr == ARRAY_TOP)
    else $error("chip erase range wrong");
  a_sector_range: assert property (
    array_req.valid && array_req.op == FWP_OP_SECTOR_ERASE
    |-> array_req.start_addr[11:0] == 12'h000 && array_req.end_addr == array_req.start_addr + 18'h00FFF)
    else $error("sector erase range wrong");
  a_aai_even: assert property (
    array_req.valid && array_req.op == FWP_OP_AAI_WORD |-> array_req.start_addr[0] == 1'b0)
    else $error("word program address odd");
  a_miso_after_fall: assert property (
    $changed(spi_miso) && !spi_miso_oe_n |-> !$past(spi_sck, 2)) else $error("output moved off edge");
endmodule : fwp_monitor
bind fwp_top fwp_monitor u_mon (.clk_sys(clk_sys), .srst(srst), .spi_sck(spi_sck),
  .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wp_n(wp_n), .array_done(array_done),
  .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .array_req(array_req));

// >>> fwp_host.sv
// Purpose: serial bus master model driving command frames
// Assumes: mode 0, sck period 8 clk_sys cycles, idle low
// Notes: data line shows the inverse of its last bit while deselected
`timescale 1ns/1ps
module fwp_host (
  input wire logic clk_sys,
  input wire logic spi_miso,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_clk
  // n bytes msb first from the top of d; rd gets the first byte after the opcode
  task automatic xfer(input logic [47:0] d, input int n, output logic [7:0] rd);
    logic [47:0] sh;
    sh = d;
    rd = 8'h00;
    @(posedge clk_sys);
    spi_cs_n <= 1'b0;
    wait_clk(4);
    for (int i = 0; i < n * 8; i++) begin
      spi_mosi <= sh[47];
      sh = sh << 1;
      wait_clk(4);
      spi_sck <= 1'b1;
      wait_clk(2);
      if (i >= 8 && i < 16) rd = {rd[6:0], spi_miso};
      wait_clk(2);
      spi_sck <= 1'b0;
    end
    wait_clk(4);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    wait_clk(10);
  endtask : xfer
endmodule : fwp_host

// >>> testbench.sv
// Purpose: self-checking bench for the write-protect and status block
// Assumes: array engine replaced by bench pulses on array_done
// Notes: every scenario waits for the frame to finish before judging
`timescale 1ns/1ps
module testbench;
  import fwp_pkg::*;
  logic clk_sys, srst, wp_n, array_done, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
  fwp_array_req_t array_req, last_req;
  logic [7:0] nreq = 8'h00;
  logic [7:0] seen, rd;
  logic miso_line;
  int mismatches, compares;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  fwp_top dut (.clk_sys(clk_sys), .srst(srst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .wp_n(wp_n), .array_done(array_done), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .array_req(array_req));
  // released line shows the inverse, so a missing enable spoils the read
  assign miso_line = spi_miso_oe_n ? ~spi_miso : spi_miso;
  fwp_host host (.clk_sys(clk_sys), .spi_miso(miso_line), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
  always @(posedge clk_sys) begin
    if (array_req.valid === 1'b1) begin
      last_req <= array_req;
      nreq <= nreq + 8'h01;
    end
  end
  task automatic conclude;
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte
  task automatic chk_req(input fwp_op_t op, input logic [17:0] s, e, input logic [15:0] d);
    chk_byte("request count", seen + 8'h01, nreq);
    seen = nreq;
    compares++;
    if (last_req.op !== op || last_req.start_addr !== s || last_req.end_addr !== e
        || (op <= FWP_OP_AAI_WORD && last_req.data !== d)) begin
      mismatches++;
      $display("ERROR request expected %h %h %h seen %h %h %h", op, s, e,
        last_req.op, last_req.start_addr, last_req.end_addr);
    end
  endtask : chk_req
  task automatic cmd(input logic [47:0] d, input int n);
    host.xfer(d, n, rd);
  endtask : cmd
  task automatic rd_st(input logic [7:0] op, input logic [7:0] exp);
    host.xfer({op, 40'h0}, 2, rd);
    chk_byte(op == OP_READ_STATUS ? "primary_status" : "sector_lock_status", exp, rd);
  endtask : rd_st
  task automatic none;
    chk_byte("request count", seen, nreq);
  endtask : none
  task automatic wen;
    cmd({OP_WRITE_ENABLE, 40'h0}, 1);
  endtask : wen
  task automatic erase(input logic [7:0] op, input logic [17:0] a);
    cmd({op, 6'h0, a, 16'h0}, 4);
  endtask : erase
  task automatic finish_op;
    @(posedge clk_sys);
    array_done <= 1'b1;
    @(posedge clk_sys);
    array_done <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : finish_op
  task automatic t_reset;
    rd_st(OP_READ_STATUS, 8'h0C);
    rd_st(OP_READ_SECTOR_LOCK, 8'h00);
  endtask : t_reset
  task automatic t_latch;
    erase(OP_SECTOR_ERASE, 18'h00000);
    none();
    cmd({OP_STATUS_WRITE, 40'h0}, 2);
    rd_st(OP_READ_STATUS, 8'h0C);
    wen();
    rd_st(OP_READ_STATUS, 8'h0E);
    erase(OP_SECTOR_ERASE, 18'h00000);
    none();
    rd_st(OP_READ_STATUS, 8'h0E);
    cmd({OP_WRITE_DISABLE, 40'h0}, 1);
    rd_st(OP_READ_STATUS, 8'h0C);
    cmd({OP_ENABLE_STATUS_WRITE, 40'h0}, 1);
    cmd({OP_STATUS_WRITE, 40'h0}, 2);
    rd_st(OP_READ_STATUS, 8'h00);
  endtask : t_latch
  task automatic t_busy;
    wen();
    erase(OP_SECTOR_ERASE, 18'h12345);
    chk_req(FWP_OP_SECTOR_ERASE, 18'h12000, 18'h12FFF, 16'h0);
    rd_st(OP_READ_STATUS, 8'h03);
    cmd({OP_WRITE_DISABLE, 40'h0}, 1);
    rd_st(OP_READ_STATUS, 8'h03);
    finish_op();
    rd_st(OP_READ_STATUS, 8'h00);
  endtask : t_busy
  task automatic t_block;
    for (int k = 1; k < 3; k++) begin
      logic [17:0] b;
      b = (k == 1) ? QUARTER_BASE : HALF_BASE;
      wen();
      cmd({OP_STATUS_WRITE, 4'h0, k[1:0], 2'h0, 32'h0}, 2);
      wen();
      erase(OP_SECTOR_ERASE, b);
      none();
      erase(OP_SECTOR_ERASE, b - 18'h01000);
      chk_req(FWP_OP_SECTOR_ERASE, b - 18'h01000, b - 18'h00001, 16'h0);
      finish_op();
      wen();
      cmd({OP_CHIP_ERASE_A, 40'h0}, 1);
      none();
      rd_st(OP_READ_STATUS, {4'h0, k[1:0], 2'h2});
    end
    wen();
    cmd({OP_STATUS_WRITE, 40'h0}, 2);
  endtask : t_block
  task automatic t_lock;
    wp_n <= 1'b0;
    wen();
    cmd({OP_STATUS_WRITE, 8'h84, 32'h0}, 2);
    rd_st(OP_READ_STATUS, 8'h84);
    wen();
    cmd({OP_STATUS_WRITE, 8'h00, 8'h0C, 24'h0}, 3);
    rd_st(OP_READ_STATUS, 8'h86);
    rd_st(OP_READ_SECTOR_LOCK, 8'h00);
    wp_n <= 1'b1;
    wen();
    cmd({OP_STATUS_WRITE, 8'h00, 8'h0C, 24'h0}, 3);
    rd_st(OP_READ_STATUS, 8'h00);
    rd_st(OP_READ_SECTOR_LOCK, 8'h0C);
  endtask : t_lock
  task automatic t_sector;
    wen();
    erase(OP_SECTOR_ERASE, TOP_SECTOR_BASE);
    erase(OP_SECTOR_ERASE, 18'h00000);
    cmd({OP_CHIP_ERASE_B, 40'h0}, 1);
    none();
    erase(OP_SECTOR_ERASE, 18'h01000);
    chk_req(FWP_OP_SECTOR_ERASE, 18'h01000, 18'h01FFF, 16'h0);
    finish_op();
    wen();
    cmd({OP_STATUS_WRITE, 16'h0, 24'h0}, 3);
    wen();
    erase(OP_BLOCK32_ERASE, 18'h2ABCD);
    chk_req(FWP_OP_BLOCK32_ERASE, 18'h28000, 18'h2FFFF, 16'h0);
    finish_op();
    wen();
    erase(OP_BLOCK64_ERASE, 18'h2ABCD);
    chk_req(FWP_OP_BLOCK64_ERASE, 18'h20000, 18'h2FFFF, 16'h0);
    finish_op();
    wen();
    cmd({OP_CHIP_ERASE_A, 40'h0}, 1);
    chk_req(FWP_OP_CHIP_ERASE, ARRAY_BASE, ARRAY_TOP, 16'h0);
    finish_op();
  endtask : t_sector
  task automatic t_prog;
    wen();
    cmd({OP_BYTE_PROGRAM, 24'h001234, 8'h5A, 8'h00}, 5);
    chk_req(FWP_OP_BYTE_PROGRAM, 18'h01234, 18'h01234, 16'h005A);
    finish_op();
    wen();
    cmd({OP_AAI_PROGRAM, 24'h000101, 8'hA1, 8'hB2}, 6);
    chk_req(FWP_OP_AAI_WORD, 18'h00100, 18'h00101, 16'hA1B2);
    rd_st(OP_READ_STATUS, 8'h43);
    finish_op();
    rd_st(OP_READ_STATUS, 8'h42);
    cmd({OP_AAI_PROGRAM, 8'hC3, 8'hD4, 24'h0}, 3);
    chk_req(FWP_OP_AAI_WORD, 18'h00102, 18'h00103, 16'hC3D4);
    finish_op();
    rd_st(OP_READ_STATUS, 8'h42);
    cmd({OP_WRITE_DISABLE, 40'h0}, 1);
    rd_st(OP_READ_STATUS, 8'h00);
  endtask : t_prog
  task automatic t_rerun;
    wen();
    cmd({OP_STATUS_WRITE, 8'h80, 8'h04, 24'h0}, 3);
    rd_st(OP_READ_SECTOR_LOCK, 8'h04);
    srst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
  endtask : t_rerun
  initial begin
    srst = 1'b1;
    wp_n = 1'b1;
    array_done = 1'b0;
    seen = 8'h00;
    mismatches = 0;
    compares = 0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_latch();
    t_busy();
    t_block();
    t_lock();
    t_sector();
    t_prog();
    t_rerun();
    conclude();
  end
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
endmodule : testbench
